// ==== src/tec_defines.vh ====
// constants of the tag surveillance command handler
// Contract
// - command b1h runs the inventory page read in its accelerated form
// - accelerated reply runs at double rate; rate flag picks high or low rate
// - downlink rate and reply delay after reader end of frame stay standard
// - accelerated reply uses only one subcarrier
// - command a2h turns surveillance on unless the state is frozen
// - command a3h turns surveillance off unless the state is frozen
// - when protected, the password must be presented before set, reset, freeze
// - set, reset, freeze use write timing and take either option value
// - command a4h freezes surveillance state and identifier for good
// - request is flags, code, maker code, optional uid, parameters, crc
// - error reply is flags, error code, crc; good reply is flags, crc
// - alarm without option: no mask sent; reply sequence when enabled
// - alarm with option: byte mask; reply only on match while enabled
// - alarm with option and zero mask replies the stored identifier
// - alarm reply carries the fixed 256 bit pattern, msb first
// - an erroneous alarm request gets no reply
// - while surveillance is off the alarm gets no reply
// - a6h after password enables protection; option picks surveillance or afi
// - once enabled a protection can never be cleared
// - protection command always runs and is timed as a write, option clear
// - a7h stores the 16 bit identifier with write timing, password if protected
// - crc, coding, bit count or framing error means silence
// - unsupported command or option: silence, even if addressed
`ifndef TEC_DEFINES_VH
`define TEC_DEFINES_VH

// ****************************************************************
// command codes
// ****************************************************************
`define TEC_CMD_FAST_READ 8'hb1
`define TEC_CMD_ON        8'ha2
`define TEC_CMD_OFF       8'ha3
`define TEC_CMD_FREEZE    8'ha4
`define TEC_CMD_ALARM     8'ha5
`define TEC_CMD_PROTECT   8'ha6
`define TEC_CMD_ID_WRITE  8'ha7

// ****************************************************************
// request flag bit positions
// ****************************************************************
`define TEC_FLG_SUBC 0
`define TEC_FLG_RATE 1
`define TEC_FLG_INV  2
`define TEC_FLG_PEXT 3
`define TEC_FLG_SEL  4
`define TEC_FLG_ADDR 5
`define TEC_FLG_OPT  6

// ****************************************************************
// reply bytes and frame layout
// ****************************************************************
`define TEC_RSP_OK    8'h00
`define TEC_RSP_ERR   8'h01
`define TEC_ERR_CODE  8'h0f
`define TEC_HDR_SHORT 5'd3
`define TEC_HDR_LONG  5'd11
`define TEC_CRC_BYTES 5'd2
`define TEC_MIN_BYTES 5'd5
`define TEC_BUF_BYTES 5'd16
`define TEC_ID_PLEN   5'd2
`define TEC_MASK_0    8'h00
`define TEC_MASK_8    8'h08
`define TEC_MASK_16   8'h10
`define TEC_LEN_OK    6'd1
`define TEC_LEN_ERR   6'd2
`define TEC_LEN_ID    6'd3
`define TEC_LEN_SEQ   6'd33

// ****************************************************************
// crc16, reflected, init ones, residue over data plus crc
// ****************************************************************
`define TEC_CRC_INIT  16'hffff
`define TEC_CRC_POLY  16'h8408
`define TEC_CRC_RESID 16'hf0b8

// ****************************************************************
// alarm pattern as written, first byte leftmost, msb sent first
// ****************************************************************
`define TEC_SEQ_A 64'hf4cd460eabe509fe
`define TEC_SEQ_B 64'h178d011c4b41926e
`define TEC_SEQ_C 64'h415b5961f6f5d10d
`define TEC_SEQ_D 64'h8f398b48a54eecf7

// ****************************************************************
// reset values of the persistent state
// ****************************************************************
`define TEC_RST_ID 16'h0000
`define TEC_RST_BIT 1'b0

`endif

// ==== src/tec_sync.v ====
// two flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module tec_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_b,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= {W{1'b0}};
         q    <= {W{1'b0}};
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== src/tec_handler.v ====
// surveillance command handler of a vicinity label
`timescale 1ns/1ps
`default_nettype none
`include "tec_defines.vh"
module tec_handler #(
   parameter [7:0] MFG_CODE = 8'h5a   // arbitrary value
) (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        link_clk,
   input  wire        link_frame,
   input  wire        link_bit,
   input  wire        link_code_err,
   input  wire [63:0] my_uid,
   input  wire        tag_selected,
   input  wire        pwd_ok,
   input  wire        nv_sv_on,
   input  wire        nv_sv_locked,
   input  wire        nv_sv_prot,
   input  wire        nv_afi_prot,
   input  wire [15:0] nv_sv_id,
   output reg         nv_wr,
   output reg         tx_valid,
   output reg  [7:0]  tx_data,
   output reg         tx_last,
   input  wire        tx_ready,
   output reg         tx_write_alike,
   output reg         tx_wait_eof,
   output reg         rsp_fast,
   output reg         rsp_high_rate,
   output reg         rsp_dual_sub,
   output reg         fast_read_req,
   output reg         sv_on,
   output reg         sv_locked,
   output reg         sv_prot,
   output reg         afi_prot,
   output reg  [15:0] sv_id
);

   // ****************************************************************
   // states and reply kinds
   // ****************************************************************
   localparam [4:0] ST_LOAD = 5'b00001;
   localparam [4:0] ST_IDLE = 5'b00010;
   localparam [4:0] ST_RX   = 5'b00100;
   localparam [4:0] ST_EVAL = 5'b01000;
   localparam [4:0] ST_TX   = 5'b10000;

   localparam [4:0] K_NONE = 5'b00001;
   localparam [4:0] K_OK   = 5'b00010;
   localparam [4:0] K_ERR  = 5'b00100;
   localparam [4:0] K_ID   = 5'b01000;
   localparam [4:0] K_SEQ  = 5'b10000;

   // ****************************************************************
   // link input sampling
   // ****************************************************************
   wire [3:0] s_link;
   wire       s_clk   = s_link[3];
   wire       s_frame = s_link[2];
   wire       s_bit   = s_link[1];
   wire       s_err   = s_link[0];
   reg        clk_d;
   reg        frame_d;

   tec_sync #(
      .W (4)
   ) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({link_clk, link_frame, link_bit, link_code_err}),
      .q     (s_link)
   );

   wire clk_rise   = s_clk & ~clk_d;
   wire frame_fall = ~s_frame & frame_d;

   // ****************************************************************
   // receive state
   // ****************************************************************
   reg [4:0]  state;
   reg [7:0]  shreg;
   reg [2:0]  bitcnt;
   reg [4:0]  nbytes;
   reg        ovf;
   reg        cerr;
   reg [15:0] crc;
   reg [7:0]  rxb [0:15];
   reg [4:0]  kind;
   reg [5:0]  tx_idx;

   wire [7:0]  next_shreg = {s_bit, shreg[7:1]};
   wire        crc_fb     = crc[0] ^ s_bit;
   wire [15:0] next_crc   = {1'b0, crc[15:1]} ^
                            (crc_fb ? `TEC_CRC_POLY : 16'h0000);
   wire        take_bit   = clk_rise & s_frame &
                            ((state == ST_IDLE) | (state == ST_RX));

   // ****************************************************************
   // request decode
   // ****************************************************************
   wire [7:0] flg  = rxb[0];
   wire [7:0] cmd  = rxb[1];
   wire [7:0] mfg  = rxb[2];
   wire       addr = flg[`TEC_FLG_ADDR];
   wire       sel  = flg[`TEC_FLG_SEL];
   wire       opt  = flg[`TEC_FLG_OPT];
   wire       inv  = flg[`TEC_FLG_INV];
   wire       pext = flg[`TEC_FLG_PEXT];
   wire [4:0] hdr  = addr ? `TEC_HDR_LONG : `TEC_HDR_SHORT;
   wire       len_ok = nbytes >= (hdr + `TEC_CRC_BYTES);
   wire [4:0] plen = nbytes - `TEC_CRC_BYTES - hdr;
   wire [3:0] pi0  = hdr[3:0];
   wire [3:0] pi1  = pi0 + 4'd1;
   wire [3:0] pi2  = pi0 + 4'd2;
   wire [7:0] p0   = rxb[pi0];
   wire [7:0] p1   = rxb[pi1];
   wire [7:0] p2   = rxb[pi2];

   // frame integrity and fixed request layout
   wire frame_ok = ~cerr & (bitcnt == 3'd0) & (crc == `TEC_CRC_RESID) &
                   (nbytes >= `TEC_MIN_BYTES) & ~ovf & len_ok;
   reg  uid_ok;
   integer i;

   always @* begin
      uid_ok = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
         if (rxb[3 + i] != my_uid[8*i +: 8]) begin
            uid_ok = 1'b0;
         end
      end
   end

   wire talk = frame_ok & (mfg == MFG_CODE) & (~addr | uid_ok) &
               (~sel | tag_selected);
   // error replies only when addressed or selected, never in inventory
   wire loud = (addr | sel) & ~inv & ~pext;
   wire is_wr = (cmd == `TEC_CMD_ON) | (cmd == `TEC_CMD_OFF) |
                (cmd == `TEC_CMD_FREEZE) | (cmd == `TEC_CMD_ID_WRITE);
   wire [4:0] need = (cmd == `TEC_CMD_ID_WRITE) ? `TEC_ID_PLEN : 5'd0;

   reg [4:0]  next_kind;
   reg        next_on;
   reg        next_lock;
   reg        next_svp;
   reg        next_afi;
   reg [15:0] next_id;
   reg        next_fast;
   reg        next_wait;
   reg        next_wr;

   always @* begin
      next_kind = K_NONE;
      next_on   = sv_on;
      next_lock = sv_locked;
      next_svp  = sv_prot;
      next_afi  = afi_prot;
      next_id   = sv_id;
      next_fast = 1'b0;
      next_wait = 1'b0;
      next_wr   = 1'b0;
      if (talk) begin
         if (cmd == `TEC_CMD_FAST_READ) begin
            next_fast = inv;
         end else if (is_wr) begin
            next_wr   = 1'b1;
            next_wait = opt;
            if (inv | pext) begin
               next_kind = K_NONE;
            end else if (plen != need) begin
               next_kind = loud ? K_ERR : K_NONE;
            end else if (sv_prot & ~pwd_ok) begin
               next_kind = loud ? K_ERR : K_NONE;
            end else if (sv_locked & (cmd != `TEC_CMD_FREEZE)) begin
               next_kind = loud ? K_ERR : K_NONE;
            end else begin
               next_kind = K_OK;
               if (cmd == `TEC_CMD_ON) begin
                  next_on = 1'b1;
               end
               if (cmd == `TEC_CMD_OFF) begin
                  next_on = 1'b0;
               end
               if (cmd == `TEC_CMD_FREEZE) begin
                  next_lock = 1'b1;
               end
               if (cmd == `TEC_CMD_ID_WRITE) begin
                  next_id = {p1, p0};
               end
            end
         end else if (cmd == `TEC_CMD_PROTECT) begin
            next_wr   = 1'b1;
            next_wait = 1'b0;
            if (inv | pext) begin
               next_kind = K_NONE;
            end else if (plen != 5'd0) begin
               next_kind = loud ? K_ERR : K_NONE;
            end else if (~pwd_ok) begin
               next_kind = loud ? K_ERR : K_NONE;
            end else begin
               next_kind = K_OK;
               // only ever set, never cleared
               if (opt) begin
                  next_afi = 1'b1;
               end else begin
                  next_svp = 1'b1;
               end
            end
         end else if (cmd == `TEC_CMD_ALARM) begin
            // silent while off and on any malformed request
            if (sv_on & ~inv & ~pext) begin
               if (~opt) begin
                  if (plen == 5'd0) begin
                     next_kind = K_SEQ;
                  end
               end else if ((plen == 5'd1) & (p0 == `TEC_MASK_0)) begin
                  next_kind = K_ID;
               end else if ((plen == 5'd2) & (p0 == `TEC_MASK_8) &
                            (p1 == sv_id[7:0])) begin
                  next_kind = K_SEQ;
               end else if ((plen == 5'd3) & (p0 == `TEC_MASK_16) &
                            (p1 == sv_id[7:0]) &
                            (p2 == sv_id[15:8])) begin
                  next_kind = K_SEQ;
               end
            end
         end
      end
   end

   // ****************************************************************
   // reply byte generation
   // ****************************************************************
   wire [255:0] seq_all = {`TEC_SEQ_A, `TEC_SEQ_B, `TEC_SEQ_C, `TEC_SEQ_D};

   function [7:0] rev8;
      input [7:0] b;
      integer j;
      begin
         for (j = 0; j < 8; j = j + 1) begin
            rev8[j] = b[7-j];
         end
      end
   endfunction

   function [5:0] rsp_len;
      input [4:0] k;
      begin
         case (k)
            K_ERR:   rsp_len = `TEC_LEN_ERR;
            K_ID:    rsp_len = `TEC_LEN_ID;
            K_SEQ:   rsp_len = `TEC_LEN_SEQ;
            default: rsp_len = `TEC_LEN_OK;
         endcase
      end
   endfunction

   reg [7:0] rsp_byte;
   reg [5:0] byte_idx;
   reg [4:0] byte_kind;
   reg [7:0] seq_sel;

   always @* begin
      seq_sel = seq_all[255 - 8*(byte_idx - 6'd1) -: 8];
      if (byte_idx == 6'd0) begin
         rsp_byte = (byte_kind == K_ERR) ? `TEC_RSP_ERR : `TEC_RSP_OK;
      end else begin
         case (byte_kind)
            K_ERR:   rsp_byte = `TEC_ERR_CODE;
            K_ID:    rsp_byte = (byte_idx == 6'd1) ? sv_id[7:0] :
                                                     sv_id[15:8];
            K_SEQ:   rsp_byte = rev8(seq_sel);
            default: rsp_byte = `TEC_RSP_OK;
         endcase
      end
   end

   always @* begin
      if (state == ST_EVAL) begin
         byte_idx  = 6'd0;
         byte_kind = next_kind;
      end else begin
         byte_idx  = tx_idx + 6'd1;
         byte_kind = kind;
      end
   end

   // ****************************************************************
   // main sequencing
   // ****************************************************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state          <= ST_LOAD;
         clk_d          <= 1'b0;
         frame_d        <= 1'b0;
         shreg          <= 8'h00;
         bitcnt         <= 3'd0;
         nbytes         <= 5'd0;
         ovf            <= 1'b0;
         cerr           <= 1'b0;
         crc            <= `TEC_CRC_INIT;
         kind           <= K_NONE;
         tx_idx         <= 6'd0;
         nv_wr          <= 1'b0;
         tx_valid       <= 1'b0;
         tx_data        <= 8'h00;
         tx_last        <= 1'b0;
         tx_write_alike <= 1'b0;
         tx_wait_eof    <= 1'b0;
         rsp_fast       <= 1'b0;
         rsp_high_rate  <= 1'b0;
         rsp_dual_sub   <= 1'b0;
         fast_read_req  <= 1'b0;
         sv_on          <= `TEC_RST_BIT;
         sv_locked      <= `TEC_RST_BIT;
         sv_prot        <= `TEC_RST_BIT;
         afi_prot       <= `TEC_RST_BIT;
         sv_id          <= `TEC_RST_ID;
      end else begin
         clk_d         <= s_clk;
         frame_d       <= s_frame;
         nv_wr         <= 1'b0;
         fast_read_req <= 1'b0;
         if (take_bit) begin
            shreg  <= next_shreg;
            bitcnt <= bitcnt + 3'd1;
            crc    <= next_crc;
            if (bitcnt == 3'd7) begin
               if (nbytes < `TEC_BUF_BYTES) begin
                  rxb[nbytes[3:0]] <= next_shreg;
                  nbytes           <= nbytes + 5'd1;
               end else begin
                  ovf <= 1'b1;
               end
            end
         end
         case (state)
            ST_LOAD: begin
               // persistent state comes back from storage
               sv_on     <= nv_sv_on;
               sv_locked <= nv_sv_locked;
               sv_prot   <= nv_sv_prot;
               afi_prot  <= nv_afi_prot;
               sv_id     <= nv_sv_id;
               state     <= ST_IDLE;
            end
            ST_IDLE: begin
               if (s_frame) begin
                  state <= ST_RX;
               end
            end
            ST_RX: begin
               cerr <= cerr | s_err;
               if (frame_fall) begin
                  state <= ST_EVAL;
               end
            end
            ST_EVAL: begin
               sv_on     <= next_on;
               sv_locked <= next_lock;
               sv_prot   <= next_svp;
               afi_prot  <= next_afi;
               sv_id     <= next_id;
               nv_wr     <= next_wr & (next_kind == K_OK);
               fast_read_req <= next_fast;
               if (talk) begin
                  // double rate and one subcarrier only when fast
                  rsp_fast      <= next_fast;
                  rsp_high_rate <= flg[`TEC_FLG_RATE];
                  rsp_dual_sub  <= flg[`TEC_FLG_SUBC] & ~next_fast;
               end
               // reply delay keeps its standard value for the fast read; write commands take write timing
               tx_write_alike <= next_wr;
               tx_wait_eof    <= next_wait;
               kind   <= next_kind;
               tx_idx <= 6'd0;
               bitcnt <= 3'd0;
               nbytes <= 5'd0;
               ovf    <= 1'b0;
               cerr   <= 1'b0;
               crc    <= `TEC_CRC_INIT;
               if (next_kind == K_NONE) begin
                  state <= ST_IDLE;
               end else begin
                  tx_valid <= 1'b1;
                  tx_data  <= rsp_byte;
                  tx_last  <= (rsp_len(next_kind) == 6'd1);
                  state    <= ST_TX;
               end
            end
            ST_TX: begin
               if (tx_ready) begin
                  if (tx_last) begin
                     tx_valid <= 1'b0;
                     tx_last  <= 1'b0;
                     state    <= ST_IDLE;
                  end else begin
                     tx_idx  <= tx_idx + 6'd1;
                     tx_data <= rsp_byte;
                     tx_last <= (tx_idx + 6'd2) == rsp_len(kind);
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== dv/tec_handler_assertions.sv ====
// port assertions of the surveillance command handler
`timescale 1ns/1ps
`default_nettype none
module tec_handler_assertions (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        nv_wr,
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_last,
   input wire logic        tx_ready,
   input wire logic        rsp_fast,
   input wire logic        rsp_dual_sub,
   input wire logic        fast_read_req,
   input wire logic        sv_on,
   input wire logic        sv_locked,
   input wire logic        sv_prot,
   input wire logic        afi_prot,
   input wire logic [15:0] sv_id
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ********************
   // properties
   // ********************
   AST_WR: assert property (nv_wr |-> tx_valid && tx_data == 8'h00)
      else $error("store without ok reply");
   AST_ST:
      assert property ($past(rst_b, 2) && $changed({sv_on, sv_id}) |-> nv_wr)
      else $error("state moved without store");
   AST_PK: assert property (!$fell(sv_prot))
      else $error("protection cleared");
   AST_AK: assert property (!$fell(afi_prot))
      else $error("afi protection cleared");
   AST_LK: assert property (!$fell(sv_locked))
      else $error("freeze cleared");
   AST_FZ:
      assert property ($past(sv_locked) |-> $stable({sv_on, sv_id}))
      else $error("frozen state changed");
   AST_SS: assert property (rsp_fast |-> !rsp_dual_sub)
      else $error("dual subcarrier on fast reply");
   AST_FQ: assert property (fast_read_req |-> !tx_valid [*8])
      else $error("reply after fast read");
   AST_HD:
      assert property (tx_valid && !tx_ready
         |=> tx_valid && $stable({tx_data, tx_last}))
      else $error("reply byte dropped while stalled");
endmodule
bind tec_handler tec_handler_assertions tec_handler_assertions_inst (
   .clk, .rst_b, .nv_wr, .tx_valid, .tx_data, .tx_last, .tx_ready, .rsp_fast,
   .rsp_dual_sub, .fast_read_req, .sv_on, .sv_locked, .sv_prot, .afi_prot,
   .sv_id);
`default_nettype wire

// ==== dv/tec_reader_model.sv ====
// reader model that sends request frames on the link pins
`timescale 1ns/1ps
`default_nettype none
module tec_reader_model (
   output logic link_clk,
   output logic link_frame,
   output logic link_bit,
   output logic link_code_err
);
   // ********************
   // request frames
   // ********************
   initial {link_clk, link_frame, link_bit, link_code_err} = 4'h0;
   // bad[0] spoils the crc, bad[1] flags a coding error on the fourth bit of the frame
   task automatic send(input int n, input logic [127:0] b,
      input logic [1:0] bad);
      logic [15:0] c;
      int          i;
      c = 16'hffff;
      for (i = 0; i < 8 * n; i++)
         c = (c[0] ^ b[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      b[8 * n +: 16] = ~c ^ {15'h0, bad[0]};
      // keep pin changes clear of the block's clock edges
      #2 link_frame = 1'b1;
      for (i = 0; i < 8 * n + 16; i++) begin
         link_bit = b[i];
         link_code_err = bad[1] && i == 3;
         #30 link_clk = 1'b1;
         #62.5 link_clk = 1'b0;
         #32.5;
      end
      link_frame = 1'b0;
      link_bit = ~link_bit;
   endtask
endmodule
`default_nettype wire

// ==== dv/tec_handler_tb_top.sv ====
// self checking bench of the surveillance command handler
`timescale 1ns/1ps
`default_nettype none
`include "tec_defines.vh"
module tec_handler_tb_top;
   logic         clk = 1'b0, rst_b = 1'b0, tx_ready = 1'b0;
   logic         pwd_ok = 1'b0, tag_selected = 1'b0;
   logic [3:0]   nv = 4'h0;
   logic [15:0]  nv_sv_id = 16'h0, id;
   logic [63:0]  my_uid = 64'h0;
   logic [255:0] rp;
   logic [8:0]   expq[$];
   int           error_cnt = 0, checks_done = 0;
   int           wr_cnt = 0, fq_cnt = 0;
   wire          link_clk, link_frame, link_bit, link_code_err, nv_wr;
   wire          tx_valid, tx_last, tx_write_alike, tx_wait_eof, rsp_fast;
   wire          rsp_high_rate, rsp_dual_sub, fast_read_req, sv_on;
   wire          sv_locked, sv_prot, afi_prot;
   wire [7:0]    tx_data;
   wire [15:0]   sv_id;
   // ********************
   // devices and helpers
   // ********************
   tec_reader_model tec_reader_model_inst (.link_clk, .link_frame,
      .link_bit, .link_code_err);
   tec_handler #(.MFG_CODE(8'h3c)) tec_handler_inst (.clk, .rst_b,
      .link_clk, .link_frame, .link_bit, .link_code_err, .my_uid,
      .tag_selected, .pwd_ok, .nv_sv_on(nv[0]), .nv_sv_locked(nv[1]),
      .nv_sv_prot(nv[2]), .nv_afi_prot(nv[3]), .nv_sv_id, .nv_wr, .tx_valid,
      .tx_data, .tx_last, .tx_ready, .tx_write_alike, .tx_wait_eof,
      .rsp_fast, .rsp_high_rate, .rsp_dual_sub, .fast_read_req, .sv_on,
      .sv_locked, .sv_prot, .afi_prot, .sv_id);
   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) error_cnt++;
      if (got !== exp) $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
   endtask
   task automatic ex(input logic [7:0] d, input logic l);
      expq.push_back({l, d});
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // k: 0 silence, 1 ok, 2 error, 3 alarm sequence, 4 stored identifier
   task automatic req(input logic [7:0] f, c, input logic [31:0] p,
      input int np, k, input logic [1:0] bad = 2'h0);
      logic [127:0] b;
      int           i;
      int           n;
      b = {104'h0, 8'h3c, c, f};
      n = f[5] ? 11 : 3;
      if (f[5]) b[87:24] = my_uid;
      b[8 * n +: 32] = p;
      if (k == 1) ex(`TEC_RSP_OK, 1'b1);
      if (k == 2) ex(`TEC_RSP_ERR, 1'b0);
      if (k == 2) ex(`TEC_ERR_CODE, 1'b1);
      if (k > 2) ex(`TEC_RSP_OK, 1'b0);
      if (k == 4) ex(id[7:0], 1'b0);
      if (k == 4) ex(id[15:8], 1'b1);
      for (i = 0; i < 32 && k == 3; i++) ex(rp[8 * i +: 8], i == 31);
      tec_reader_model_inst.send(n + np, b, bad);
      for (i = 0; i < 800 && expq.size() > 0; i++) @(posedge clk);
      repeat (20) @(posedge clk);
      chk(expq.size(), 0);
      @(negedge clk);
   endtask
   always #5 clk = ~clk;
   // the reply coder stalls at random
   always @(negedge clk) tx_ready <= ($urandom % 4) != 0;
   always @(posedge clk)
      if (tx_valid === 1'b1 && tx_ready === 1'b1 && expq.size() == 0)
         chk(tx_data, 9'h1ff);
      else if (tx_valid === 1'b1 && tx_ready === 1'b1)
         chk({tx_last, tx_data}, expq.pop_front());
   // count store and page read pulses
   always @(posedge clk) begin
      if (nv_wr === 1'b1) wr_cnt++;
      if (fast_read_req === 1'b1) fq_cnt++;
   end
   // ********************
   // scenarios
   // ********************
   initial begin
      void'($urandom(8701));
      nv_sv_id = 16'($urandom);
      my_uid = {$urandom, $urandom};
      rp = {<<{`TEC_SEQ_A, `TEC_SEQ_B, `TEC_SEQ_C, `TEC_SEQ_D}};
      id = nv_sv_id;
      repeat (8) @(posedge clk);
      @(negedge clk) rst_b = 1'b1;
      repeat (6) @(negedge clk);
      req(0, 8'ha5, 0, 0, 0);
      req(0, 8'ha2, 0, 0, 1);
      req(0, 8'ha5, 0, 0, 3);
      req(8'h40, 8'ha5, 0, 1, 4);
      req(8'h40, 8'ha5, {id[7:0], 8'h08}, 2, 3);
      req(8'h40, 8'ha5, {~id[7:0], 8'h08}, 2, 0);
      req(8'h40, 8'ha5, {id, 8'h10}, 3, 3);
      req(0, 8'ha5, 0, 0, 0, 2'h1);
      req(0, 8'ha5, 0, 0, 0, 2'h2);
      id = 16'($urandom);
      req(8'h40, 8'ha7, id, 2, 1);
      req(8'h20, 8'ha6, 0, 0, 2);
      pwd_ok = 1'b1;
      req(8'h41, 8'ha6, 0, 0, 1);
      chk({tx_write_alike, rsp_dual_sub}, 2'h3);
      chk({tx_wait_eof, sv_prot, afi_prot, sv_id}, {3'h1, id});
      req(0, 8'ha6, 0, 0, 1);
      pwd_ok = 1'b0;
      tag_selected = 1'b1;
      req(8'h10, 8'ha3, 0, 0, 2);
      pwd_ok = 1'b1;
      req(8'h60, 8'ha3, 0, 0, 1);
      chk({tx_wait_eof, sv_on, sv_prot}, 3'h5);
      chk({tx_write_alike, rsp_high_rate}, 2'h2);
      req(0, 8'ha4, 0, 0, 1);
      req(8'h20, 8'ha2, 0, 0, 2);
      req(0, 8'ha7, ~id, 2, 0);
      chk({sv_locked, sv_on, sv_id}, {2'h2, id});
      // mid-run reset reloads the persistent state from storage
      nv = 4'hf;
      nv_sv_id = id;
      rst_b = 1'b0;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      chk({afi_prot, sv_prot, sv_locked, sv_on, sv_id}, {4'hf, id});
      req(8'h07, 8'hb1, 0, 3, 0);
      chk({rsp_fast, rsp_high_rate, rsp_dual_sub}, 3'h6);
      chk({tx_write_alike, fq_cnt[7:0], wr_cnt[7:0]}, 17'h00106);
      report_and_stop;
   end
   initial begin
      #900000;
      chk(0, 1);
      report_and_stop;
   end
endmodule
`default_nettype wire
